// ---- hdl/frame_bus_if.sv ----
`timescale 1ns/1ps
// Purpose: carrier between the control logic and the frame store
// Assumes: single clock, one access per cycle
// Notes: cell word is {full, inverse, code}
interface frame_bus_if;
	logic       wr_en;
	logic [9:0] addr;
	logic [9:0] wdata;
	logic [9:0] rdata;
	modport ctrl  (output wr_en, output addr, output wdata, input rdata);
	modport store (input wr_en, input addr, input wdata, output rdata);
endinterface

// ---- hdl/frame_store.sv ----
`timescale 1ns/1ps
// Purpose: character cell memory, one entry per byte column per text line
// Assumes: write and read share one address, read is registered
// Notes: the attribute bits travel with the code so old cells keep them
module frame_store (
	input wire logic         sys_clk, // system clock
	frame_bus_if.store       fb       // cell access
);
	logic [9:0] mem [lcd_pkg::CELL_COUNT];

	// ------------------------------------------------------------
	// storage, no reset so it maps onto block memory
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (fb.wr_en && fb.addr < 10'(lcd_pkg::CELL_COUNT)) begin
			mem[fb.addr] <= fb.wdata;
		end
		fb.rdata <= (fb.addr < 10'(lcd_pkg::CELL_COUNT)) ? mem[fb.addr] : 10'h000;
	end
endmodule

// ---- hdl/lcd_pkg.sv ----
// Purpose: constants and types shared by the cursor and window control block
// Assumes: one 100 MHz system clock, host strobes already synchronous
// Notes: register offsets are byte indices selected by the instruction cycle
// Summary of operation
// - cursor steps one byte across, one row down in graphics, one text line down in text
// - column 04h third glyph, row 10h second line
// - cursor addresses frame memory, optional auto increase
// - cursor movement held inside active window
// - cursor on/off/blink, blink = count times frame
// - cursor height 1 to 16 rows from nibble
// - fixed width eight pixels when glyph width off
// - glyph width on: sixteen after full, eight half
// - active window is sub-rectangle of display window
// - inverse bit latched per character at write
// - align bit puts full glyphs on even columns, except an odd column at the active window's right edge
// - column match raises interrupt when enabled
// - busy refuses frame memory, registers still accepted
package lcd_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CURSOR_CTRL   = 8'h08;
	localparam logic [7:0] OFS_TEXT_CTRL     = 8'h10;
	localparam logic [7:0] OFS_CURSOR_SHAPE  = 8'h18;
	localparam logic [7:0] OFS_ACT_RIGHT     = 8'h20;
	localparam logic [7:0] OFS_DISP_RIGHT    = 8'h28;
	localparam logic [7:0] OFS_ACT_BOTTOM    = 8'h30;
	localparam logic [7:0] OFS_DISP_BOTTOM   = 8'h38;
	localparam logic [7:0] OFS_ACT_LEFT      = 8'h40;
	localparam logic [7:0] OFS_DISP_LEFT     = 8'h48;
	localparam logic [7:0] OFS_ACT_TOP       = 8'h50;
	localparam logic [7:0] OFS_DISP_TOP      = 8'h58;
	localparam logic [7:0] OFS_CURSOR_COL    = 8'h60;
	localparam logic [7:0] OFS_CURSOR_ROW    = 8'h70;
	localparam logic [7:0] OFS_BLINK_PERIOD  = 8'h80;
	localparam logic [7:0] OFS_INT_ENABLE    = 8'ha0;
	localparam logic [7:0] OFS_COL_MATCH     = 8'hb0;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BIT_WIDTH_BY_GLYPH = 0;
	localparam int BIT_CURSOR_ON      = 1;
	localparam int BIT_CURSOR_BLINK   = 2;
	localparam int BIT_AUTO_INC       = 3;
	localparam int BIT_GRAPHICS       = 3;
	localparam int BIT_INVERSE        = 5;
	localparam int BIT_ALIGN          = 6;
	localparam int BIT_COL_INT_EN     = 0;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_SHAPE      = 8'h10;
	localparam logic [7:0] RST_BLINK      = 8'h10;
	localparam logic [7:0] RST_RIGHT      = 8'h27;
	localparam logic [7:0] RST_BOTTOM     = 8'hef;
	// ------------------------------------------------------------
	// geometry and timing
	// ------------------------------------------------------------
	localparam logic [7:0] LEAD_MIN       = 8'h80;
	localparam logic [7:0] TEXT_LINE_ROWS = 8'h10;
	localparam int CELLS_PER_LINE         = 40;
	localparam int CELL_COUNT             = 600;
	localparam logic [4:0] WIDTH_HALF     = 5'h08;
	localparam logic [4:0] WIDTH_FULL     = 5'h10;
	localparam int BUSY_CYCLES            = 4;
	localparam int CLK_PERIOD_NS          = 10;
	localparam int FRAME_PERIOD_NS        = 16_666_667;
	localparam int FRAME_CYCLES_DEF       = FRAME_PERIOD_NS / CLK_PERIOD_NS;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_TRAIL  = 4'b0010,
		ST_SECOND = 4'b0100,
		ST_BUSY   = 4'b1000
	} wr_state_t;
endpackage

// ---- hdl/lcd_text_cursor_window_control.sv ----
`timescale 1ns/1ps
// Purpose: cursor, window, blink and character write control
// Assumes: host strobes are synchronous to sys_clk
// Notes: rs high selects register cycles, rs low selects frame memory data
module lcd_text_cursor_window_control #(
	parameter int FRAME_CYCLES = lcd_pkg::FRAME_CYCLES_DEF // cycles per frame
) (
	input  wire logic       sys_clk,       // 100 MHz clock
	input  wire logic       rst,           // async reset, high
	input  wire logic       cs_n,          // chip select, low
	input  wire logic       wr_n,          // write strobe, low
	input  wire logic       rd_n,          // read strobe, low
	input  wire logic       rs,            // 1 register, 0 data
	input  wire logic [7:0] db_in,         // data bus input
	output logic      [7:0] db_out,        // data bus output
	output logic            db_oe,         // data bus drive enable
	output logic            busy,          // frame memory busy
	output logic            int_out,       // column match interrupt
	output logic            cursor_visible,// cursor drawn now
	output logic      [8:0] cursor_x_px,   // cursor left pixel
	output logic      [7:0] cursor_y,      // cursor top row
	output logic      [4:0] cursor_width,  // cursor width in pixels
	output logic      [4:0] cursor_height  // cursor height in rows
);
	frame_bus_if fb ();
	frame_store u_store (.sys_clk(sys_clk), .fb(fb));

	logic [7:0] cursor_ctrl, text_ctrl, cursor_shape_ctrl, blink_period_count;
	logic [7:0] act_right, act_bottom, act_left, act_top;
	logic [7:0] disp_right, disp_bottom, disp_left, disp_top;
	logic [7:0] int_enable, column_match_value, reg_index;
	logic [5:0] cursor_column_pos;
	logic [7:0] cursor_row_pos;
	logic       wr_n_d, rd_n_d, reg_phase, last_full;
	logic [7:0] lead_byte, trail_byte;
	logic [5:0] glyph_col;
	logic       glyph_inv;
	logic [2:0] busy_cnt;
	lcd_pkg::wr_state_t state, next_state;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [9:0] cell_index(input logic [5:0] c, input logic [7:0] r);
		cell_index = 10'(r[7:4] * lcd_pkg::CELLS_PER_LINE) + 10'(c);
	endfunction
	function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
		max8 = (a > b) ? a : b;
	endfunction
	function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
		min8 = (a < b) ? a : b;
	endfunction

	// active window clipped to the panel area
	logic [5:0] win_left, win_right;
	logic [7:0] win_top, win_bottom;
	assign win_left   = 6'(max8(act_left, disp_left));
	assign win_right  = 6'(min8(act_right, disp_right));
	assign win_top    = max8(act_top, disp_top);
	assign win_bottom = min8(act_bottom, disp_bottom);

	logic graphics, wr_go, rd_done, data_wr, reg_wr;
	assign graphics = text_ctrl[lcd_pkg::BIT_GRAPHICS];
	assign wr_go    = !cs_n && !wr_n && wr_n_d;
	assign rd_done  = !cs_n && rd_n && !rd_n_d && !rs;
	assign data_wr  = wr_go && !rs;
	assign reg_wr   = wr_go && rs && reg_phase;

	// ------------------------------------------------------------
	// strobe edge history
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wr_n_d <= 1'b1;
			rd_n_d <= 1'b1;
		end else begin
			wr_n_d <= wr_n;
			rd_n_d <= rd_n;
		end
	end

	// ------------------------------------------------------------
	// register file; commands stay open while busy
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_phase <= 1'b0; reg_index <= 8'h00;
			cursor_ctrl <= 8'h00; text_ctrl <= 8'h00;
			cursor_shape_ctrl <= lcd_pkg::RST_SHAPE;
			blink_period_count <= lcd_pkg::RST_BLINK;
			act_right <= lcd_pkg::RST_RIGHT; act_bottom <= lcd_pkg::RST_BOTTOM;
			disp_right <= lcd_pkg::RST_RIGHT; disp_bottom <= lcd_pkg::RST_BOTTOM;
			act_left <= 8'h00; act_top <= 8'h00; disp_left <= 8'h00; disp_top <= 8'h00;
			int_enable <= 8'h00; column_match_value <= 8'h00;
		end else if (wr_go && rs) begin
			// first byte names the register, second carries the value
			reg_phase <= !reg_phase;
			if (!reg_phase) begin
				reg_index <= db_in;
			end else begin
				case (reg_index)
					lcd_pkg::OFS_CURSOR_CTRL:  cursor_ctrl <= db_in;
					lcd_pkg::OFS_TEXT_CTRL:    text_ctrl <= db_in;
					lcd_pkg::OFS_CURSOR_SHAPE: cursor_shape_ctrl <= db_in;
					lcd_pkg::OFS_BLINK_PERIOD: blink_period_count <= db_in;
					lcd_pkg::OFS_ACT_RIGHT:    act_right <= db_in;
					lcd_pkg::OFS_ACT_BOTTOM:   act_bottom <= db_in;
					lcd_pkg::OFS_ACT_LEFT:     act_left <= db_in;
					lcd_pkg::OFS_ACT_TOP:      act_top <= db_in;
					lcd_pkg::OFS_DISP_RIGHT:   disp_right <= db_in;
					lcd_pkg::OFS_DISP_BOTTOM:  disp_bottom <= db_in;
					lcd_pkg::OFS_DISP_LEFT:    disp_left <= db_in;
					lcd_pkg::OFS_DISP_TOP:     disp_top <= db_in;
					lcd_pkg::OFS_INT_ENABLE:   int_enable <= db_in;
					lcd_pkg::OFS_COL_MATCH:    column_match_value <= db_in;
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// character write sequencer
	// ------------------------------------------------------------
	logic take_data, is_lead;
	assign take_data = data_wr && (state == lcd_pkg::ST_IDLE || state == lcd_pkg::ST_TRAIL);
	assign is_lead   = !graphics && db_in >= lcd_pkg::LEAD_MIN && state == lcd_pkg::ST_IDLE;

	always_comb begin
		next_state = state;
		case (state)
			lcd_pkg::ST_IDLE:   if (data_wr) next_state = is_lead ? lcd_pkg::ST_TRAIL : lcd_pkg::ST_BUSY;
			lcd_pkg::ST_TRAIL:  if (data_wr) next_state = lcd_pkg::ST_SECOND;
			lcd_pkg::ST_SECOND: next_state = lcd_pkg::ST_BUSY;
			lcd_pkg::ST_BUSY:   if (busy_cnt == 3'(lcd_pkg::BUSY_CYCLES - 1)) next_state = lcd_pkg::ST_IDLE;
			default:            next_state = lcd_pkg::ST_IDLE;
		endcase
	end

	// state, busy pin and glyph capture; data writes in busy are dropped
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= lcd_pkg::ST_IDLE; busy <= 1'b0; busy_cnt <= 3'h0;
			lead_byte <= 8'h00; trail_byte <= 8'h00; glyph_col <= 6'h00;
			glyph_inv <= 1'b0; last_full <= 1'b0;
		end else begin
			state    <= next_state;
			busy     <= next_state == lcd_pkg::ST_SECOND || next_state == lcd_pkg::ST_BUSY;
			busy_cnt <= (state == lcd_pkg::ST_BUSY) ? busy_cnt + 3'h1 : 3'h0;
			if (take_data && state == lcd_pkg::ST_IDLE) begin
				// inverse sampled per character, earlier cells untouched
				glyph_inv <= text_ctrl[lcd_pkg::BIT_INVERSE];
				lead_byte <= db_in;
				// full glyphs start on an even column when aligned, unless the odd cursor column is already win_right
				glyph_col <= (is_lead && text_ctrl[lcd_pkg::BIT_ALIGN] && cursor_column_pos[0]
					&& cursor_column_pos < win_right) ? cursor_column_pos + 6'h1 : cursor_column_pos;
				if (!is_lead) last_full <= 1'b0;
			end
			if (take_data && state == lcd_pkg::ST_TRAIL) begin
				trail_byte <= db_in;
				last_full  <= 1'b1;
			end
		end
	end

	// cell writes at the cursor position, full glyph cells at glyph_col and glyph_col + 1
	always_comb begin
		fb.wr_en = 1'b0;
		fb.addr  = cell_index(cursor_column_pos, cursor_row_pos);
		fb.wdata = 10'h000;
		if (take_data && state == lcd_pkg::ST_IDLE && !is_lead) begin
			fb.wr_en = 1'b1;
			fb.wdata = {1'b0, text_ctrl[lcd_pkg::BIT_INVERSE], db_in};
		end else if (take_data && state == lcd_pkg::ST_TRAIL) begin
			fb.wr_en = 1'b1;
			fb.addr  = cell_index(glyph_col, cursor_row_pos);
			fb.wdata = {1'b1, glyph_inv, lead_byte};
		end else if (state == lcd_pkg::ST_SECOND) begin
			fb.wr_en = 1'b1;
			fb.addr  = cell_index(glyph_col + 6'h1, cursor_row_pos);
			fb.wdata = {1'b1, glyph_inv, trail_byte};
		end
	end

	// ------------------------------------------------------------
	// cursor position and auto increase
	// ------------------------------------------------------------
	logic       step_now;
	logic [5:0] step_base, next_col;
	logic [7:0] next_row, row_step;
	always_comb begin
		step_now  = 1'b0;
		step_base = cursor_column_pos;
		if (state == lcd_pkg::ST_SECOND) begin
			step_now  = 1'b1;
			step_base = glyph_col + 6'h1;
		end else if ((take_data && state == lcd_pkg::ST_IDLE && !is_lead) || (rd_done && !busy)) begin
			step_now = 1'b1;
		end
		step_now = step_now && cursor_ctrl[lcd_pkg::BIT_AUTO_INC];
		// one byte across, one row or one text line down
		row_step = graphics ? 8'h01 : lcd_pkg::TEXT_LINE_ROWS;
		next_col = step_base + 6'h1;
		next_row = cursor_row_pos;
		if (step_base >= win_right) begin
			next_col = win_left;
			next_row = (cursor_row_pos > win_bottom - row_step) ? win_top : cursor_row_pos + row_step;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cursor_column_pos <= 6'h00;
			cursor_row_pos    <= 8'h00;
		end else if (reg_wr && reg_index == lcd_pkg::OFS_CURSOR_COL) begin
			// host placements are clipped into the window
			cursor_column_pos <= 6'(min8(max8(db_in, 8'(win_left)), 8'(win_right)));
		end else if (reg_wr && reg_index == lcd_pkg::OFS_CURSOR_ROW) begin
			cursor_row_pos <= min8(max8(db_in, win_top), win_bottom);
		end else if (step_now) begin
			cursor_column_pos <= next_col;
			cursor_row_pos    <= next_row;
		end
	end

	// ------------------------------------------------------------
	// frame timing and blink phase
	// ------------------------------------------------------------
	logic [20:0] frame_cnt;
	logic [7:0]  blink_cnt;
	logic        frame_tick, blink_phase;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			frame_cnt <= 21'h0; frame_tick <= 1'b0;
		end else begin
			frame_tick <= frame_cnt == 21'(FRAME_CYCLES - 1);
			frame_cnt  <= (frame_cnt == 21'(FRAME_CYCLES - 1)) ? 21'h0 : frame_cnt + 21'h1;
		end
	end

	// toggle after blink_period_count frames; zero count never toggles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blink_cnt <= 8'h00; blink_phase <= 1'b1;
		end else if (frame_tick && blink_period_count != 8'h00) begin
			if (blink_cnt >= blink_period_count - 8'h01) begin
				blink_cnt <= 8'h00; blink_phase <= !blink_phase;
			end else begin
				blink_cnt <= blink_cnt + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cursor_visible <= 1'b0; cursor_x_px <= 9'h000; cursor_y <= 8'h00;
			cursor_width  <= lcd_pkg::WIDTH_HALF; int_out <= 1'b0;
			// height follows the shape reset value so it agrees from the first edge
			cursor_height <= {1'b0, lcd_pkg::RST_SHAPE[7:4]} + 5'h01;
		end else begin
			cursor_visible <= cursor_ctrl[lcd_pkg::BIT_CURSOR_ON]
				&& (!cursor_ctrl[lcd_pkg::BIT_CURSOR_BLINK] || blink_phase);
			cursor_x_px   <= {cursor_column_pos, 3'h0};
			cursor_y      <= cursor_row_pos;
			cursor_height <= {1'b0, cursor_shape_ctrl[7:4]} + 5'h01;
			cursor_width  <= (cursor_ctrl[lcd_pkg::BIT_WIDTH_BY_GLYPH] && last_full && !graphics)
				? lcd_pkg::WIDTH_FULL : lcd_pkg::WIDTH_HALF;
			int_out <= int_enable[lcd_pkg::BIT_COL_INT_EN]
				&& 8'(cursor_column_pos) == column_match_value;
		end
	end

	// host read data, registers or the cell under the cursor
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			db_out <= 8'h00; db_oe <= 1'b0;
		end else begin
			db_oe <= !cs_n && !rd_n;
			case (reg_index)
				lcd_pkg::OFS_CURSOR_CTRL:  db_out <= rs ? cursor_ctrl : fb.rdata[7:0];
				lcd_pkg::OFS_TEXT_CTRL:    db_out <= rs ? text_ctrl : fb.rdata[7:0];
				lcd_pkg::OFS_CURSOR_SHAPE: db_out <= rs ? cursor_shape_ctrl : fb.rdata[7:0];
				lcd_pkg::OFS_BLINK_PERIOD: db_out <= rs ? blink_period_count : fb.rdata[7:0];
				lcd_pkg::OFS_CURSOR_COL:   db_out <= rs ? 8'(cursor_column_pos) : fb.rdata[7:0];
				lcd_pkg::OFS_CURSOR_ROW:   db_out <= rs ? cursor_row_pos : fb.rdata[7:0];
				lcd_pkg::OFS_COL_MATCH:    db_out <= rs ? column_match_value : fb.rdata[7:0];
				default:                   db_out <= rs ? 8'h00 : fb.rdata[7:0];
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_busy_no_write:  assert property (state == lcd_pkg::ST_BUSY |-> !fb.wr_en)
		else $error("frame write while busy");
	a_reg_while_busy: assert property (busy && reg_wr && reg_index == lcd_pkg::OFS_TEXT_CTRL
		|=> text_ctrl == $past(db_in)) else $error("register refused while busy");
	a_step_in_window: assert property ($past(step_now) && win_left <= win_right
		|-> cursor_column_pos >= win_left && cursor_column_pos <= win_right)
		else $error("cursor left active window");
	a_wrap_to_left:   assert property (step_now && step_base >= win_right
		|=> cursor_column_pos == $past(win_left)) else $error("no wrap at edge");
	a_height_map:     assert property (##1 $stable(cursor_shape_ctrl)
		|=> cursor_height == 5'($past(cursor_shape_ctrl, 2) >> 4) + 5'h01)
		else $error("cursor height wrong");
	a_width_fixed:    assert property (!cursor_ctrl[lcd_pkg::BIT_WIDTH_BY_GLYPH]
		|=> cursor_width == lcd_pkg::WIDTH_HALF) else $error("width not eight");
	a_width_full:     assert property (cursor_ctrl[lcd_pkg::BIT_WIDTH_BY_GLYPH] && last_full
		&& !graphics |=> cursor_width == lcd_pkg::WIDTH_FULL) else $error("width not 16");
	a_col_match_int:  assert property (int_enable[0] && 8'(cursor_column_pos) == column_match_value
		|=> int_out) else $error("match interrupt missing");
	a_blink_on_frame: assert property ($changed(blink_phase) |-> $past(frame_tick))
		else $error("blink toggled off frame");
	a_full_aligned:   assert property (state == lcd_pkg::ST_SECOND && text_ctrl[lcd_pkg::BIT_ALIGN]
		&& $stable(text_ctrl) && glyph_col < win_right |-> !glyph_col[0] || win_left[0])
		else $error("full glyph misaligned");
	c_full_glyph:  cover property (state == lcd_pkg::ST_TRAIL ##1 state == lcd_pkg::ST_SECOND);
	c_wrap:        cover property (step_now && step_base >= win_right);
	c_int:         cover property ($rose(int_out));
	c_blink:       cover property ($rose(blink_phase));
endmodule

// ---- verification/host_model.sv ----
`timescale 1ns/1ps
// Purpose: host microcontroller driving the parallel register and data bus
// Assumes: every task is entered just after a rising sys_clk edge
// Notes: released data lines show the inverse byte, never the stale one
module host_model (
	input  wire logic       sys_clk, // system clock
	input  wire logic       busy,    // device busy flag
	input  wire logic [7:0] db_out,  // device read data
	input  wire logic       db_oe,   // device drives data bus
	output logic            cs_n,    // chip select, low
	output logic            wr_n,    // write strobe, low
	output logic            rd_n,    // read strobe, low
	output logic            rs,      // 1 register, 0 data
	output logic      [7:0] db_in    // host write data
);
	initial begin
		cs_n  = 1'b1;
		wr_n  = 1'b1;
		rd_n  = 1'b1;
		rs    = 1'b1;
		db_in = 8'h00;
	end

	// one write strobe, held a full cycle so the device sees its falling edge
	task automatic strobe(input logic sel, input logic [7:0] val);
		cs_n  <= 1'b0;
		rs    <= sel;
		wr_n  <= 1'b0;
		db_in <= val;
		@(posedge sys_clk);
		wr_n  <= 1'b1;
		db_in <= ~val;
		@(posedge sys_clk);
	endtask

	// index byte then value byte, never held off by busy
	task automatic reg_write(input logic [7:0] idx, input logic [7:0] val);
		strobe(1'b1, idx);
		strobe(1'b1, val);
	endtask

	// poll may be switched off to start a write without waiting for busy to fall
	task automatic data_write(input logic [7:0] code, input logic poll);
		if (poll) begin
			@(posedge sys_clk);
			while (busy) @(posedge sys_clk);
		end
		strobe(1'b0, code);
	endtask

	// full glyph travels as lead then trail byte, half glyph as one byte
	task automatic glyph(input logic [15:0] code);
		if (code[15:8] != 8'h00) data_write(code[15:8], 1'b1);
		data_write(code[7:0], 1'b1);
	endtask

	// level read; result carries the drive enable above the byte
	task automatic read(input logic sel, output logic [8:0] res);
		cs_n <= 1'b0;
		rs   <= sel;
		rd_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		res = {db_oe, db_out};
		rd_n <= 1'b1;
		@(posedge sys_clk);
	endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
// Purpose: register and character sequences against the cursor block
// Assumes: FRAME_CYCLES shortened to 8 so blinking is quick
// Notes: outputs are read a few edges after each access has settled, except busy right after its write
module testbench;
	logic       sys_clk, rst, cs_n, wr_n, rd_n, rs, db_oe, busy, int_out, vis, last;
	logic [7:0] db_in, db_out, cursor_y;
	logic [8:0] x, rd;
	logic [4:0] width, height;
	int         miscompares, total_checks, cycles, flips;

	lcd_text_cursor_window_control #(.FRAME_CYCLES(8)) u_dut (.sys_clk(sys_clk), .rst(rst),
		.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .rs(rs), .db_in(db_in), .db_out(db_out),
		.db_oe(db_oe), .busy(busy), .int_out(int_out), .cursor_visible(vis),
		.cursor_x_px(x), .cursor_y(cursor_y), .cursor_width(width), .cursor_height(height));
	host_model u_host (.sys_clk(sys_clk), .busy(busy), .db_out(db_out), .db_oe(db_oe),
		.cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .rs(rs), .db_in(db_in));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic settle();
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic test_done();
		if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// hang guard, far above the length of the sequence
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end

	initial begin
		rst = 1'b1;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk("width", 9'h008, {4'h0, width});
		chk("height", 9'h002, {4'h0, height});
		u_host.strobe(1'b1, lcd_pkg::OFS_BLINK_PERIOD);
		u_host.read(1'b1, rd);
		chk("blink_reg", {1'b1, lcd_pkg::RST_BLINK}, rd);
		// close the open pair with the same value, then aim at an unused index
		u_host.strobe(1'b1, lcd_pkg::RST_BLINK);
		u_host.reg_write(8'hc8, 8'h5a);
		u_host.read(1'b1, rd);
		chk("unmapped", 9'h100, rd);
		// every height code, 1 to 16 rows
		for (int n = 0; n < 16; n++) begin
			u_host.reg_write(lcd_pkg::OFS_CURSOR_SHAPE, 8'(n << 4));
			settle();
			chk("height", 9'(n + 1), {4'h0, height});
		end
		u_host.reg_write(lcd_pkg::OFS_CURSOR_COL, 8'h04);
		u_host.reg_write(lcd_pkg::OFS_CURSOR_ROW, 8'h10);
		u_host.reg_write(lcd_pkg::OFS_INT_ENABLE, 8'h01);
		u_host.reg_write(lcd_pkg::OFS_COL_MATCH, 8'h04);
		settle();
		chk("x", 9'h020, x);
		chk("y", 9'h010, {1'b0, cursor_y});
		chk("int", 9'h001, {8'h00, int_out});
		u_host.reg_write(lcd_pkg::OFS_CURSOR_COL, 8'h05);
		settle();
		chk("int", 9'h000, {8'h00, int_out});
		// aligned full glyph from an odd column, then a half glyph
		u_host.reg_write(lcd_pkg::OFS_TEXT_CTRL, 8'h40);
		u_host.reg_write(lcd_pkg::OFS_CURSOR_CTRL, 8'h09);
		u_host.reg_write(lcd_pkg::OFS_CURSOR_COL, 8'h03);
		u_host.glyph(16'hb7e7);
		settle();
		chk("x", 9'h030, x);
		chk("width", 9'h010, {4'h0, width});
		u_host.glyph(16'h0045);
		settle();
		chk("width", 9'h008, {4'h0, width});
		u_host.reg_write(lcd_pkg::OFS_CURSOR_COL, 8'h06);
		u_host.read(1'b0, rd);
		settle();
		chk("cell", 9'h145, rd);
		chk("x", 9'h038, x);
		// unaligned full glyph, fixed width
		u_host.reg_write(lcd_pkg::OFS_TEXT_CTRL, 8'h00);
		u_host.reg_write(lcd_pkg::OFS_CURSOR_CTRL, 8'h08);
		u_host.reg_write(lcd_pkg::OFS_CURSOR_COL, 8'h03);
		u_host.glyph(16'ha6f6);
		settle();
		chk("x", 9'h028, x);
		chk("width", 9'h008, {4'h0, width});
		// second write lands while busy and is dropped
		u_host.reg_write(lcd_pkg::OFS_CURSOR_COL, 8'h0a);
		u_host.data_write(8'h45, 1'b0);
		u_host.data_write(8'h45, 1'b0);
		settle();
		chk("x", 9'h058, x);
		u_host.data_write(8'h45, 1'b0);
		u_host.reg_write(lcd_pkg::OFS_CURSOR_COL, 8'h14);
		settle();
		chk("x", 9'h0a0, x);
		// control register value lands while the data write is still busy
		u_host.data_write(8'h45, 1'b0);
		chk("busy", 9'h001, {8'h00, busy});
		u_host.reg_write(lcd_pkg::OFS_TEXT_CTRL, 8'h20);
		u_host.read(1'b1, rd);
		chk("text_ctrl", 9'h120, rd);
		u_host.reg_write(lcd_pkg::OFS_TEXT_CTRL, 8'h00);
		// narrow active window: clamp and wrap
		u_host.reg_write(lcd_pkg::OFS_ACT_LEFT, 8'h02);
		u_host.reg_write(lcd_pkg::OFS_ACT_RIGHT, 8'h05);
		u_host.reg_write(lcd_pkg::OFS_CURSOR_ROW, 8'h00);
		u_host.reg_write(lcd_pkg::OFS_CURSOR_COL, 8'h20);
		settle();
		chk("x", 9'h028, x);
		u_host.glyph(16'h0045);
		settle();
		chk("x", 9'h010, x);
		chk("y", 9'h010, {1'b0, cursor_y});
		// steady cursor, then blinking every 2 frames of 8 cycles
		u_host.reg_write(lcd_pkg::OFS_CURSOR_CTRL, 8'h02);
		settle();
		chk("visible", 9'h001, {8'h00, vis});
		u_host.reg_write(lcd_pkg::OFS_BLINK_PERIOD, 8'h02);
		u_host.reg_write(lcd_pkg::OFS_CURSOR_CTRL, 8'h06);
		settle();
		last = vis;
		repeat (64) begin
			@(posedge sys_clk);
			if (vis !== last) flips++;
			last = vis;
		end
		chk("blink_flips", 9'h004, 9'(flips));
		test_done();
	end
endmodule
